// ---- nvm_access_controller.sv ----
// Nonvolatile memory access controller: flash, user IDs and data EEPROM
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_controller_defs.svh"

module nvm_access_controller #(
	parameter int OP_CYCLES = `NVM_OP_CYCLES,
	parameter logic [13:0] REV_ID = 14'h0A5A, // Arbitrary value
	parameter logic [13:0] DEV_ID = 14'h1234, // Arbitrary value
	parameter logic [3:0] CFG_INIT = `NVM_CFG_ERASED
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire nvm_access_pkg::regAccess_t regAccess,
	input wire logic doneClr,
	input wire logic nvm_done_irq_en,
	input wire logic indReq,
	input wire logic indirect_write_op,
	input wire logic [15:0] indirect_pointer,
	input wire nvm_access_pkg::pgmReq_t pgmReq,
	output logic [14:0] nvmAddr,
	output logic [13:0] nvmData,
	output logic [7:0] nvm_control,
	output logic nvm_done_flag,
	output logic nvmIrq,
	output logic cpuStall,
	output logic [13:0] indirect_data,
	output logic indValid,
	output logic [13:0] pgmRdata,
	output logic pgmDone,
	output logic pgmRefused,
	output logic program_read_lock_n,
	output logic eeprom_read_lock_n,
	output logic [1:0] self_write_protect_sel
);
	import nvm_access_pkg::*;

	// Arrays carry no reset: they model nonvolatile contents
	logic [13:0] flashMem [`NVM_FLASH_WORDS];
	logic [13:0] idMem [`NVM_ID_WORDS];
	logic [7:0] eeMem [`NVM_EE_BYTES];
	logic [13:0] latchMem [`NVM_ROW_WORDS];
	logic [`NVM_ROW_WORDS-1:0] latchValid_q;
	logic [3:0] cfg_q;
	logic [14:0] addr_q;
	logic [13:0] data_q;
	logic rd_q, wr_q, permit_q, free_q, latchOnly_q, region_q;
	ctrlState_t state_q;
	unlockState_t unlock_q;
	opKind_t op_q;
	logic [31:0] cnt_q;
	logic [12:0] bulkIdx_q;
	logic doneFlag_q;
	logic [13:0] indData_q;
	logic indValid_q;
	logic [13:0] pgmRdata_q;
	logic pgmDone_q, pgmRefused_q;

	logic codeLocked, ctrlWrite, rdStart, wrReq, wrStart, eeAddr, idAddr, wpHit;
	logic latchLoad, opEnd, pgmLocked, pgmServe, bulkEnd, opStart;
	logic [12:0] wpLimit;
	logic [13:0] readWord;

	assign codeLocked = !cfg_q[`NVM_CFG_PROG_LOCK_N] || !cfg_q[`NVM_CFG_EE_LOCK_N];
	assign ctrlWrite = regAccess.wr && regAccess.sel == SEL_CTRL;
	assign rdStart = ctrlWrite && regAccess.wdata[`NVM_CTL_RD] && state_q == ST_IDLE
		&& !codeLocked;
	assign wrReq = ctrlWrite && regAccess.wdata[`NVM_CTL_WR] && state_q == ST_IDLE;
	// Strobe only counts after 55h/AAh and with writes permitted
	assign wrStart = wrReq && unlock_q == UNL_ARMED && permit_q && !codeLocked;
	assign eeAddr = region_q && addr_q[14:8] == `NVM_EE_ADDR_HI;
	assign idAddr = region_q && addr_q < 15'(`NVM_ID_WORDS);

	// Protected span grows as the field value falls; 11 protects nothing
	always_comb begin
		unique case (cfg_q[`NVM_CFG_WP_HI:`NVM_CFG_WP_LO])
			2'b11: wpLimit = 13'h0000;
			2'b10: wpLimit = `NVM_WP_LIMIT_SMALL;
			2'b01: wpLimit = `NVM_WP_LIMIT_HALF;
			2'b00: wpLimit = 13'h1FFF;
		endcase
	end
	assign wpHit = !region_q && (addr_q[12:0] < wpLimit || cfg_q[3:2] == 2'b00);
	assign latchLoad = wrStart && !free_q && (!region_q || idAddr);
	assign opStart = wrStart && !rdStart && (eeAddr || (idAddr || !region_q && !wpHit)
		&& (free_q || !latchOnly_q));

	// Register-side read mux; unmapped configuration space reads zero
	always_comb begin
		readWord = 14'h0000;
		if (!region_q) begin
			readWord = addr_q[14:13] == 2'b00 ? flashMem[addr_q[12:0]] : 14'h0000;
		end else if (eeAddr) begin
			readWord = {6'h00, eeMem[addr_q[7:0]]};
		end else if (idAddr) begin
			readWord = idMem[addr_q[1:0]];
		end else if (addr_q == `NVM_ADDR_REV) begin
			readWord = REV_ID;
		end else if (addr_q == `NVM_ADDR_DEV) begin
			readWord = DEV_ID;
		end else if (addr_q == `NVM_ADDR_CFG) begin
			readWord = {10'h000, cfg_q};
		end
	end

	// Address, data and control registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			addr_q <= 15'h0000;
			data_q <= 14'h0000;
			{rd_q, wr_q, permit_q, free_q, latchOnly_q, region_q} <= 6'h00;
		end else begin
			if (regAccess.wr && regAccess.sel == SEL_ADDR_LO) addr_q[7:0] <= regAccess.wdata;
			if (regAccess.wr && regAccess.sel == SEL_ADDR_HI) addr_q[14:8] <= regAccess.wdata[6:0];
			if (regAccess.wr && regAccess.sel == SEL_DATA_LO) data_q[7:0] <= regAccess.wdata;
			if (regAccess.wr && regAccess.sel == SEL_DATA_HI) data_q[13:8] <= regAccess.wdata[5:0];
			if (ctrlWrite) begin
				permit_q <= regAccess.wdata[`NVM_CTL_PERMIT];
				free_q <= regAccess.wdata[`NVM_CTL_FREE];
				latchOnly_q <= regAccess.wdata[`NVM_CTL_LATCH_ONLY];
				region_q <= regAccess.wdata[`NVM_CTL_REGION];
			end
			if (rdStart) rd_q <= 1'b1;
			if (state_q == ST_READ) begin
				data_q <= readWord;
				rd_q <= 1'b0;
			end
			// Latch-only loads and protected rows never raise the strobe
			if (opStart) wr_q <= 1'b1;
			if (opEnd) wr_q <= 1'b0;
		end
	end

	// Unlock tracker: 55h then AAh then write strobe, nothing in between
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			unlock_q <= UNL_IDLE;
		end else if (regAccess.wr || regAccess.rd) begin
			unlock_q <= UNL_IDLE;
			if (regAccess.wr && regAccess.sel == SEL_KEY) begin
				if (regAccess.wdata == `NVM_KEY_FIRST) unlock_q <= UNL_GOT1;
				if (regAccess.wdata == `NVM_KEY_SECOND && unlock_q == UNL_GOT1) unlock_q <= UNL_ARMED;
			end
		end
	end

	// Sequencer: read stall, timed operation, programmer bulk erase sweep
	assign opEnd = state_q == ST_BUSY && cnt_q == 32'(OP_CYCLES - 1);
	assign bulkEnd = state_q == ST_BULK && bulkIdx_q == 13'h1FFF;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			op_q <= OP_ROW_ERASE;
			cnt_q <= 32'h0000_0000;
			bulkIdx_q <= 13'h0000;
		end else begin
			cnt_q <= state_q == ST_BUSY ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
			bulkIdx_q <= state_q == ST_BULK ? bulkIdx_q + 13'h0001 : 13'h0000;
			unique case (state_q)
				ST_IDLE: begin
					if (rdStart) begin
						state_q <= ST_READ;
					end else if (wrStart && eeAddr) begin
						op_q <= OP_EE_WRITE;
						state_q <= ST_BUSY;
					end else if (wrStart && idAddr && (free_q || !latchOnly_q)) begin
						op_q <= free_q ? OP_ID_ERASE : OP_ID_PROG;
						state_q <= ST_BUSY;
					end else if (wrStart && !region_q && !wpHit && (free_q || !latchOnly_q)) begin
						op_q <= free_q ? OP_ROW_ERASE : OP_ROW_PROG;
						state_q <= ST_BUSY;
					end else if (pgmServe && pgmReq.op == PGM_BULK) begin
						state_q <= ST_BULK;
					end
				end
				ST_READ: state_q <= ST_IDLE;
				ST_BUSY: if (opEnd) state_q <= ST_IDLE;
				ST_BULK: if (bulkEnd) state_q <= ST_IDLE;
			endcase
		end
	end
	// CPU held while an access or operation is in flight
	assign cpuStall = state_q == ST_READ || state_q == ST_BUSY || rdStart || wrStart
		|| (indReq && !indirect_write_op);

	// Programmer port is served only while the sequencer idles
	assign pgmServe = pgmReq.req && state_q == ST_IDLE && !rdStart && !wrStart;
	assign pgmLocked = pgmReq.op != PGM_BULK && (pgmReq.region
		&& pgmReq.addr[14:8] == `NVM_EE_ADDR_HI ? !cfg_q[`NVM_CFG_EE_LOCK_N]
		: !cfg_q[`NVM_CFG_PROG_LOCK_N]);

	// All nonvolatile contents are written here and nowhere else
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			latchValid_q <= 32'h0000_0000;
			cfg_q <= CFG_INIT;
		end else begin
			if (latchLoad) begin
				latchMem[addr_q[4:0]] <= data_q;
				latchValid_q[addr_q[4:0]] <= 1'b1;
			end
			if (opEnd) begin
				unique case (op_q)
					OP_ROW_ERASE: for (int i = 0; i < `NVM_ROW_WORDS; i++) begin
						flashMem[{addr_q[12:5], 5'(i)}] <= `NVM_ERASED_WORD;
					end
					OP_ROW_PROG: begin
						for (int i = 0; i < `NVM_ROW_WORDS; i++) begin
							// Untouched latches leave their word as is
							if (latchValid_q[i]) begin
								flashMem[{addr_q[12:5], 5'(i)}] <=
									flashMem[{addr_q[12:5], 5'(i)}] & latchMem[i];
							end
						end
						latchValid_q <= 32'h0000_0000;
					end
					OP_ID_ERASE: for (int i = 0; i < `NVM_ID_WORDS; i++) begin
						idMem[i] <= `NVM_ERASED_WORD;
					end
					OP_ID_PROG: begin
						for (int i = 0; i < `NVM_ID_WORDS; i++) begin
							if (latchValid_q[i]) idMem[i] <= idMem[i] & latchMem[i];
						end
						latchValid_q <= 32'h0000_0000;
					end
					OP_EE_WRITE: eeMem[addr_q[7:0]] <= data_q[7:0];
				endcase
			end
			// Programmer writes ignore self-write protection
			if (pgmServe && pgmReq.op == PGM_WRITE && !pgmLocked) begin
				if (!pgmReq.region) begin
					flashMem[pgmReq.addr[12:0]] <= flashMem[pgmReq.addr[12:0]] & pgmReq.wdata;
				end else if (pgmReq.addr[14:8] == `NVM_EE_ADDR_HI) begin
					eeMem[pgmReq.addr[7:0]] <= pgmReq.wdata[7:0];
				end else if (pgmReq.addr < 15'(`NVM_ID_WORDS)) begin
					idMem[pgmReq.addr[1:0]] <= idMem[pgmReq.addr[1:0]] & pgmReq.wdata;
				end else if (pgmReq.addr == `NVM_ADDR_CFG) begin
					cfg_q <= cfg_q & pgmReq.wdata[3:0];
				end
			end
			// Sweep clears everything; protection lifts only at the end
			if (state_q == ST_BULK) begin
				flashMem[bulkIdx_q] <= `NVM_ERASED_WORD;
				eeMem[bulkIdx_q[7:0]] <= 8'hFF;
				idMem[bulkIdx_q[1:0]] <= `NVM_ERASED_WORD;
				if (bulkEnd) cfg_q <= `NVM_CFG_ERASED;
			end
		end
	end

	// Set wins over a simultaneous clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			doneFlag_q <= 1'b0;
		end else if (opEnd) begin
			doneFlag_q <= 1'b1;
		end else if (doneClr) begin
			doneFlag_q <= 1'b0;
		end
	end

	// Indirect path only reads; write requests fall through
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			indData_q <= 14'h0000;
			indValid_q <= 1'b0;
		end else begin
			indValid_q <= indReq && !indirect_write_op;
			if (indReq && !indirect_write_op) begin
				if (indirect_pointer[15:8] == `NVM_EE_PTR_HI) begin
					indData_q <= {6'h00, eeMem[indirect_pointer[7:0]]};
				end else if (indirect_pointer[`NVM_FLASH_PTR_BIT]) begin
					indData_q <= flashMem[indirect_pointer[12:0]];
				end else begin
					indData_q <= 14'h0000;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pgmRdata_q <= 14'h0000;
			pgmDone_q <= 1'b0;
			pgmRefused_q <= 1'b0;
		end else begin
			pgmDone_q <= (pgmServe && pgmReq.op != PGM_BULK && !pgmLocked) || bulkEnd;
			pgmRefused_q <= pgmServe && pgmLocked;
			if (pgmServe && pgmReq.op == PGM_READ && !pgmLocked) begin
				pgmRdata_q <= !pgmReq.region ? flashMem[pgmReq.addr[12:0]]
					: pgmReq.addr[14:8] == `NVM_EE_ADDR_HI ? {6'h00, eeMem[pgmReq.addr[7:0]]}
					: pgmReq.addr == `NVM_ADDR_CFG ? {10'h000, cfg_q} : idMem[pgmReq.addr[1:0]];
			end
		end
	end

	assign nvmAddr = addr_q;
	assign nvmData = data_q;
	assign nvm_control = {1'b0, region_q, latchOnly_q, free_q, 1'b0, permit_q, wr_q, rd_q};
	assign nvm_done_flag = doneFlag_q;
	assign nvmIrq = doneFlag_q && nvm_done_irq_en;
	assign indirect_data = indData_q;
	assign indValid = indValid_q;
	assign pgmRdata = pgmRdata_q;
	assign pgmDone = pgmDone_q;
	assign pgmRefused = pgmRefused_q;
	assign program_read_lock_n = cfg_q[`NVM_CFG_PROG_LOCK_N];
	assign eeprom_read_lock_n = cfg_q[`NVM_CFG_EE_LOCK_N];
	assign self_write_protect_sel = cfg_q[`NVM_CFG_WP_HI:`NVM_CFG_WP_LO];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_READ_DONE: assert property (rdStart |=> state_q == ST_READ && rd_q ##1 !rd_q
		&& state_q == ST_IDLE) else $error("Read strobe did not complete in two cycles");
	AST_READ_STALL: assert property (state_q == ST_READ |-> cpuStall)
		else $error("CPU not stalled during read");
	AST_UNLOCK_NEEDED: assert property ($rose(state_q == ST_BUSY)
		|-> $past(unlock_q) == UNL_ARMED) else $error("Operation started without unlock");
	AST_REG_REFUSE: assert property (codeLocked && ctrlWrite
		|=> !rd_q && state_q != ST_BUSY) else $error("Register access taken while protected");
	AST_PGM_REFUSE: assert property (pgmServe && pgmLocked |=> pgmRefused && !pgmDone)
		else $error("Programmer access not refused");
	AST_OP_STALL: assert property (state_q == ST_BUSY |-> cpuStall && nvm_control[1])
		else $error("CPU ran or strobe dropped during operation");
	AST_DONE_SET: assert property (opEnd |=> nvm_done_flag && !nvm_control[1])
		else $error("Completion not signalled");
	AST_WP_SKIP: assert property (wrStart && free_q && wpHit
		|=> state_q == ST_IDLE && !wr_q) else $error("Protected row erase not skipped");
	AST_KEY_RESET: assert property (regAccess.wr && regAccess.sel != SEL_KEY
		|| regAccess.rd |=> unlock_q == UNL_IDLE) else $error("Unlock tracker kept a stray step");
	AST_IND_EE: assert property (indReq && !indirect_write_op
		&& indirect_pointer[15:8] == 8'h70 |=> indValid && indirect_data[13:8] == 6'h00)
		else $error("Bad EEPROM read");
	COV_READ: cover property (rdStart ##2 state_q == ST_IDLE);
	COV_EE_WRITE: cover property (op_q == OP_EE_WRITE && opEnd);
	COV_ROW_ERASE: cover property (op_q == OP_ROW_ERASE && opEnd);
	COV_BULK: cover property (bulkEnd);
endmodule
`default_nettype wire

// ---- nvm_access_controller_defs.svh ----
// Constants for the nonvolatile memory access controller
`ifndef NVM_ACCESS_CONTROLLER_DEFS_SVH
`define NVM_ACCESS_CONTROLLER_DEFS_SVH

`define NVM_FLASH_WORDS 8192
`define NVM_FLASH_AW 13
`define NVM_WORD_W 14
`define NVM_ROW_WORDS 32
`define NVM_EE_BYTES 256
`define NVM_ID_WORDS 4
`define NVM_ERASED_WORD 14'h3FFF
`define NVM_EE_PTR_HI 8'h70
`define NVM_EE_ADDR_HI 7'h70
`define NVM_FLASH_PTR_BIT 15
`define NVM_ADDR_REV 15'h0005
`define NVM_ADDR_DEV 15'h0006
`define NVM_ADDR_CFG 15'h0007
`define NVM_KEY_FIRST 8'h55
`define NVM_KEY_SECOND 8'hAA
// Control register bit positions
`define NVM_CTL_RD 0
`define NVM_CTL_WR 1
`define NVM_CTL_PERMIT 2
`define NVM_CTL_FREE 4
`define NVM_CTL_LATCH_ONLY 5
`define NVM_CTL_REGION 6
// Configuration word field positions
`define NVM_CFG_PROG_LOCK_N 0
`define NVM_CFG_EE_LOCK_N 1
`define NVM_CFG_WP_LO 2
`define NVM_CFG_WP_HI 3
`define NVM_CFG_ERASED 4'hF
// Self-write protect limits: words below the limit are protected
`define NVM_WP_LIMIT_SMALL 13'h0400
`define NVM_WP_LIMIT_HALF 13'h1000
// Self-timed operation length
`define NVM_CLK_PERIOD_NS 5
`define NVM_OP_TIME_NS 2000
`define NVM_OP_CYCLES ((`NVM_OP_TIME_NS) / (`NVM_CLK_PERIOD_NS))

`endif

// ---- nvm_access_controller_tb.sv ----
// Self-checking bench for the nonvolatile memory access controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin badCount++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module nvm_access_controller_tb;
	import nvm_access_pkg::*;
	localparam logic [13:0] DEV_IDENT = 14'h2c3d; // Arbitrary value
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic doneClr = 1'b0;
	logic irqEn = 1'b0;
	pgmReq_t pgmReq = '0;
	regAccess_t regAccess;
	logic indReq, indWrOp, nvm_done_flag, nvmIrq, cpuStall, indValid, pgmDone, pgmRefused;
	logic [15:0] indPtr;
	logic [14:0] nvmAddr;
	logic [13:0] nvmData, indData, pgmRdata, w, dw;
	logic [7:0] nvm_control;
	logic program_read_lock_n, eeprom_read_lock_n, stl, vld;
	logic [1:0] self_write_protect_sel;
	int badCount = 0;
	int testsRun = 0;
	int k;

	always #2.5 sys_clk = ~sys_clk;

	nvm_access_controller #(.OP_CYCLES(4), .DEV_ID(DEV_IDENT)) nvm_access_controller_i (
		.sys_clk(sys_clk), .rst(rst), .regAccess(regAccess), .doneClr(doneClr),
		.nvm_done_irq_en(irqEn), .indReq(indReq), .indirect_write_op(indWrOp),
		.indirect_pointer(indPtr), .pgmReq(pgmReq), .nvmAddr(nvmAddr), .nvmData(nvmData),
		.nvm_control(nvm_control), .nvm_done_flag(nvm_done_flag), .nvmIrq(nvmIrq),
		.cpuStall(cpuStall), .indirect_data(indData), .indValid(indValid),
		.pgmRdata(pgmRdata), .pgmDone(pgmDone), .pgmRefused(pgmRefused),
		.program_read_lock_n(program_read_lock_n), .eeprom_read_lock_n(eeprom_read_lock_n),
		.self_write_protect_sel(self_write_protect_sel));

	nvm_cpu_model nvm_cpu_model_i (.sys_clk(sys_clk), .regAccess(regAccess), .indReq(indReq),
		.indirect_write_op(indWrOp), .indirect_pointer(indPtr), .indirect_data(indData),
		.indValid(indValid), .cpuStall(cpuStall));

	task automatic giveVerdict();
		if (badCount == 0 && testsRun > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Bounded wait: a refused operation must stay quiet for the whole window
	task automatic waitFlag(input int lim, input logic exp);
		int i;
		for (i = 0; i < lim && nvm_done_flag !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		`CHK("done flag", exp, nvm_done_flag)
		`CHK("write strobe", 1'b0, nvm_control[1])
		`CHK("irq", exp & irqEn, nvmIrq)
		if (exp && nvm_done_flag !== 1'b1) giveVerdict();
		@(posedge sys_clk);
		doneClr <= 1'b1;
		@(posedge sys_clk);
		doneClr <= 1'b0;
	endtask

	task automatic doOp(input logic [7:0] c, input logic run);
		nvm_cpu_model_i.unlock(c);
		#1;
		if (run) `CHK("stall busy", 1'b1, cpuStall)
		if (run) `CHK("strobe busy", 1'b1, nvm_control[1])
		waitFlag(run ? 40 : 8, run);
	endtask

	task automatic rdWord(input logic rg, input logic [7:0] hi, input logic [7:0] lo);
		nvm_cpu_model_i.regRead(rg, hi, lo);
		@(posedge sys_clk);
		#1;
		w = nvmData;
		`CHK("read strobe", 1'b0, nvm_control[0])
	endtask

	task automatic progWord(input logic [7:0] lo, input logic [13:0] d);
		nvm_cpu_model_i.setAddr(8'h00, lo);
		nvm_cpu_model_i.regWr(SEL_DATA_HI, {2'b00, d[13:8]});
		nvm_cpu_model_i.regWr(SEL_DATA_LO, d[7:0]);
		doOp(8'h26, 1'b0);
		doOp(8'h06, 1'b1);
	endtask

	task automatic pgm(input pgmOp_t op, input logic rg, input logic [14:0] a,
		input logic [13:0] d, input logic expDone);
		int i;
		@(posedge sys_clk);
		pgmReq <= '{req: 1'b1, op: op, region: rg, addr: a, wdata: d};
		@(posedge sys_clk);
		pgmReq.req <= 1'b0;
		#1;
		for (i = 0; i < 9000 && pgmDone !== 1'b1 && pgmRefused !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		`CHK("programmer done", expDone, pgmDone)
		`CHK("programmer refused", ~expDone, pgmRefused)
		w = pgmRdata;
		if (i >= 9000) giveVerdict();
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		`CHK("control reset", 8'h00, nvm_control)
		`CHK("lock reset", 2'b11, {program_read_lock_n, eeprom_read_lock_n})
		`CHK("protect reset", 2'b11, self_write_protect_sel)
		pgm(PGM_BULK, 1'b0, 15'h0000, 14'h0000, 1'b1);
		pgm(PGM_READ, 1'b0, 15'h1fff, 14'h0000, 1'b1);
		`CHK("erased word", 14'h3fff, w)
		pgm(PGM_WRITE, 1'b0, 15'h0060, 14'h0abc, 1'b1);
		progWord(8'h41, 14'h1234);
		progWord(8'h40, 14'h2aaa);
		progWord(8'h41, 14'h0f0f);
		rdWord(1'b0, 8'h00, 8'h40);
		`CHK("flash 40", 14'h2aaa, w)
		rdWord(1'b0, 8'h00, 8'h41);
		`CHK("flash 41", 14'h0204, w)
		nvm_cpu_model_i.setAddr(8'h00, 8'h45);
		doOp(8'h16, 1'b1);
		for (k = 0; k < 2; k++) begin
			rdWord(1'b0, 8'h00, 8'(8'h40 + k));
			`CHK("row erased", 14'h3fff, w)
		end
		rdWord(1'b0, 8'h00, 8'h60);
		`CHK("next row", 14'h0abc, w)
		nvm_cpu_model_i.indRead(16'h8060, 1'b0, stl, vld, dw);
		`CHK("ind flash", 14'h0abc, dw)
		for (k = 0; k < 2; k++) begin
			irqEn <= (k == 0);
			nvm_cpu_model_i.setAddr(8'h70, 8'(8'h12 + k));
			nvm_cpu_model_i.regWr(SEL_DATA_LO, 8'(8'h5a + k));
			doOp(8'h46, 1'b1);
		end
		for (k = 0; k < 2; k++) begin
			rdWord(1'b1, 8'h70, 8'(8'h12 + k));
			`CHK("ee byte", 8'(8'h5a + k), w[7:0])
			nvm_cpu_model_i.indRead(16'(16'h7012 + k), 1'b0, stl, vld, dw);
			`CHK("ind stall", 1'b1, stl)
			`CHK("ind valid", 1'b1, vld)
			`CHK("ind ee", 8'(8'h5a + k), dw[7:0])
		end
		nvm_cpu_model_i.indRead(16'h7012, 1'b1, stl, vld, dw);
		`CHK("ind write valid", 1'b0, vld)
		nvm_cpu_model_i.regWr(SEL_DATA_LO, 8'hc3);
		nvm_cpu_model_i.regWr(SEL_CTRL, 8'h44);
		nvm_cpu_model_i.regWr(SEL_KEY, 8'h55);
		nvm_cpu_model_i.regWr(SEL_ADDR_LO, 8'h12);
		nvm_cpu_model_i.regWr(SEL_KEY, 8'haa);
		nvm_cpu_model_i.regWr(SEL_CTRL, 8'h46);
		#1;
		waitFlag(8, 1'b0);
		rdWord(1'b1, 8'h70, 8'h12);
		`CHK("ee kept", 8'h5a, w[7:0])
		rdWord(1'b1, 8'h00, 8'h06);
		`CHK("device id", DEV_IDENT, w)
		`CHK("address pair", 15'h0006, nvmAddr)
		nvm_cpu_model_i.regWr(SEL_DATA_LO, 8'h00);
		doOp(8'h46, 1'b0);
		rdWord(1'b1, 8'h00, 8'h07);
		`CHK("config kept", 4'hf, w[3:0])
		pgm(PGM_WRITE, 1'b1, 15'h0007, 14'h3ff3, 1'b1);
		`CHK("protect all", 2'b00, self_write_protect_sel)
		nvm_cpu_model_i.setAddr(8'h00, 8'h60);
		doOp(8'h16, 1'b0);
		pgm(PGM_WRITE, 1'b0, 15'h0061, 14'h0555, 1'b1);
		rdWord(1'b0, 8'h00, 8'h60);
		`CHK("protected row", 14'h0abc, w)
		rdWord(1'b0, 8'h00, 8'h61);
		`CHK("programmer word", 14'h0555, w)
		pgm(PGM_WRITE, 1'b1, 15'h0007, 14'h3ffe, 1'b1);
		`CHK("locked", 1'b0, program_read_lock_n)
		pgm(PGM_READ, 1'b0, 15'h0060, 14'h0000, 1'b0);
		rdWord(1'b0, 8'h00, 8'h40);
		`CHK("refused read", 14'h0555, nvmData)
		pgm(PGM_BULK, 1'b0, 15'h0000, 14'h0000, 1'b1);
		`CHK("unlocked", 3'b111, {program_read_lock_n, self_write_protect_sel})
		rdWord(1'b0, 8'h00, 8'h60);
		`CHK("bulk erased", 14'h3fff, w)
		giveVerdict();
	end
endmodule
`default_nettype wire

// ---- nvm_access_pkg.sv ----
// Types shared by the nonvolatile memory access controller
package nvm_access_pkg;
	typedef enum logic [2:0] {SEL_ADDR_LO, SEL_ADDR_HI, SEL_DATA_LO, SEL_DATA_HI,
		SEL_CTRL, SEL_KEY} regSel_t;
	typedef struct packed {
		logic wr;
		logic rd;
		regSel_t sel;
		logic [7:0] wdata;
	} regAccess_t;
	typedef enum logic [1:0] {PGM_READ, PGM_WRITE, PGM_BULK} pgmOp_t;
	typedef struct packed {
		logic req;
		pgmOp_t op;
		logic region;
		logic [14:0] addr;
		logic [13:0] wdata;
	} pgmReq_t;
	typedef enum logic [3:0] {ST_IDLE = 4'b0001, ST_READ = 4'b0010, ST_BUSY = 4'b0100,
		ST_BULK = 4'b1000} ctrlState_t;
	typedef enum logic [2:0] {UNL_IDLE = 3'b001, UNL_GOT1 = 3'b010,
		UNL_ARMED = 3'b100} unlockState_t;
	typedef enum logic [2:0] {OP_ROW_ERASE, OP_ROW_PROG, OP_ID_ERASE, OP_ID_PROG,
		OP_EE_WRITE} opKind_t;
endpackage

// ---- nvm_cpu_model.sv ----
// CPU core model: register strobes, unlock steps and indirect reads
`timescale 1ns/1ps
`default_nettype none
module nvm_cpu_model
	import nvm_access_pkg::*;
(
	input wire logic sys_clk,
	output var nvm_access_pkg::regAccess_t regAccess,
	output var logic indReq,
	output var logic indirect_write_op,
	output var logic [15:0] indirect_pointer,
	input wire logic [13:0] indirect_data,
	input wire logic indValid,
	input wire logic cpuStall
);
	initial begin
		regAccess = '0;
		indReq = 1'b0;
		indirect_write_op = 1'b0;
		indirect_pointer = 16'h0000;
	end

	// One-cycle write strobe, launched and dropped on rising edges
	task automatic regWr(input regSel_t s, input logic [7:0] d);
		@(posedge sys_clk);
		regAccess <= '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
		@(posedge sys_clk);
		regAccess <= '0;
	endtask

	task automatic setAddr(input logic [7:0] hi, input logic [7:0] lo);
		regWr(SEL_ADDR_HI, hi);
		regWr(SEL_ADDR_LO, lo);
	endtask

	task automatic regRead(input logic rg, input logic [7:0] hi, input logic [7:0] lo);
		regWr(SEL_CTRL, {1'b0, rg, 6'h00});
		setAddr(hi, lo);
		regWr(SEL_CTRL, {1'b0, rg, 6'h01});
	endtask

	// This core has no interrupts, so nothing can split the keys
	task automatic unlock(input logic [7:0] c);
		regWr(SEL_CTRL, c & 8'hfc);
		regWr(SEL_KEY, 8'h55);
		regWr(SEL_KEY, 8'haa);
		regWr(SEL_CTRL, c);
	endtask

	task automatic indRead(input logic [15:0] p, input logic wrOp, output logic stl,
		output logic vld, output logic [13:0] d);
		@(posedge sys_clk);
		indReq <= 1'b1;
		indirect_pointer <= p;
		indirect_write_op <= wrOp;
		#1 stl = cpuStall;
		@(posedge sys_clk);
		indReq <= 1'b0;
		indirect_write_op <= 1'b0;
		#1 vld = indValid;
		d = indirect_data;
	endtask
endmodule
`default_nettype wire
